// >>> design/bmc_top.sv
// Purpose: Control and cycle/page counters of an on-chip bus activity monitor.
// Assumes: APB slave, zero-wait after a registered setup; inputs synchronous.
// Notes: Enable, clear, preset and debug pause go out to per-layer counters.
// How it works
// R1 - Count graphics transfers that change page
// R2 - Two-bit code picks 2k to 16k pages
// R3 - Software writes zeros to page size upper bits
// R4 - Every graphics transfer is one independent access
// R5 - Counting stays off after reset
// R6 - Any clear write zeroes resettable counters
// R7 - Preset loads read addresses, stops counting
// R8 - Gate bit pauses debug-sensitive counters on acknowledge
// R9 - Control bit 1 enables all counters but the free cycle counter
// R10 - Control bit 0 enables debug output, resets set
// R11 - Software writes zeros to control upper bits
// R12 - Free cycle counter never cleared, wraps
// R13 - Enabled cycle counter counts while enabled
// R14 - Non-debug counter pauses during gated acknowledge
// R15 - Peripheral identity bytes in four registers
// R16 - Configuration zero, revision starts at zero
// R17 - Four registers give fixed cell identity
// R18 - Output bus packs per-layer subpackets
// R19 - Graphics master raises request per transfer
// R20 - Compare and keep page above size
// R21 - Counters 32 bits, reads have no effect
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.svh"
module bmc_top
   import bmc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
   // Identity values below are arbitrary.
   parameter logic [3:0] REVISION = 4'h0,
   parameter logic [7:0] DESIGNER = 8'h5a,
   parameter logic [11:0] PART_NUMBER = 12'h3c7,
   parameter logic [31:0] CELL_ID = 32'h5e1c_a7e0
)
(
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_graphics_transfer_request,
   input wire logic i_graphics_address_ready,
   input wire logic [31:0] i_graphics_address,
   input wire logic i_debug_acknowledge,
   input wire logic [3:0] i_graphics_subpacket,
   input wire logic [5:0] i_data_subpacket,
   input wire logic [3:0] i_instr_subpacket,
   input wire logic [4:0] i_dma0_subpacket,
   input wire logic [4:0] i_dma1_subpacket,
   input wire logic [4:0] i_exp_subpacket,
   input wire logic [3:0] i_lcd_subpacket,
   output logic [32:0] o_monitor_output_bus,
   output logic o_counter_enable,
   output logic o_counter_clear,
   output logic o_counter_preset,
   output logic o_debug_pause
);
   bmc_top_s st;
   bmc_top_s next_st;
   bmc_page_if pif ();
   logic [7:0] addr;
   logic setup;
   logic wr_stb;
   logic pause;
   logic sw_clear;
   logic sw_preset;
   logic [31:0] periph_id;
   logic [31:0] rd_val;
   logic rd_ok;

   // -----------------------------------------------------------------------
   // Page tracker.
   // -----------------------------------------------------------------------
   assign pif.xfer_valid = i_graphics_transfer_request && i_graphics_address_ready; // R19
   assign pif.xfer_addr = i_graphics_address;
   assign pif.page_size = st.page_size;

   bmc_page_tracker u_tracker (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .pif(pif)
   );

   // -----------------------------------------------------------------------
   // Bus decode and read data.
   // -----------------------------------------------------------------------
   assign addr = 8'(i_paddr);
   assign setup = i_psel && !i_penable;
   assign wr_stb = i_psel && i_penable && st.pready && i_pwrite;
   assign sw_clear = wr_stb && (addr == `BMC_OFS_CLEAR);
   assign sw_preset = wr_stb && (addr == `BMC_OFS_PRESET);
   assign pause = st.dbg_gate && i_debug_acknowledge;
   assign periph_id = {`BMC_ID_CONFIG, REVISION, DESIGNER, PART_NUMBER}; // R16

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      case (addr)
         `BMC_OFS_CTRL: rd_val = {29'h0, st.dbg_gate, st.count_en, st.dbg_out_en};
         `BMC_OFS_PAGE_SIZE: rd_val = {30'h0, st.page_size};
         `BMC_OFS_CLEAR: rd_val = 32'h0000_0000;
         `BMC_OFS_PRESET: rd_val = 32'h0000_0000;
         `BMC_OFS_FREE: rd_val = st.free_cnt; // R21
         `BMC_OFS_EN_CYC: rd_val = st.en_cnt;
         `BMC_OFS_ND_CYC: rd_val = st.nd_cnt;
         `BMC_OFS_PAGE_CNT: rd_val = st.page_cnt;
         default: begin
            if ((addr & `BMC_ID_BLOCK_MASK) == `BMC_OFS_PERIPH_ID0 && addr[1:0] == 2'h0) begin
               rd_val = {24'h0, periph_id[{addr[3:2], 3'h0} +: 8]}; // R15
            end else if ((addr & `BMC_ID_BLOCK_MASK) == `BMC_OFS_CELL_ID0 &&
                  addr[1:0] == 2'h0) begin
               rd_val = {24'h0, CELL_ID[{addr[3:2], 3'h0} +: 8]}; // R17
            end else begin
               rd_ok = 1'b0;
            end
         end
      endcase
   end

   // -----------------------------------------------------------------------
   // Next state.
   // -----------------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.pready = setup;
      next_st.pslverr = setup && !rd_ok;
      next_st.prdata = (setup && !i_pwrite && rd_ok) ? rd_val : 32'h0000_0000;
      if (wr_stb && addr == `BMC_OFS_CTRL) begin
         next_st.dbg_out_en = i_pwdata[`BMC_CTRL_DBG_OUT]; // R10
         next_st.count_en = i_pwdata[`BMC_CTRL_COUNT_EN]; // R9
         next_st.dbg_gate = i_pwdata[`BMC_CTRL_DBG_GATE]; // R8
      end
      if (wr_stb && addr == `BMC_OFS_PAGE_SIZE) begin
         next_st.page_size = i_pwdata[1:0]; // R2
      end
      next_st.free_cnt = st.free_cnt + 32'h1; // R12
      if (st.count_en) begin
         next_st.en_cnt = st.en_cnt + 32'h1; // R13
      end
      if (st.count_en && !pause) begin
         next_st.nd_cnt = st.nd_cnt + 32'h1; // R14
      end
      if (st.count_en && pif.page_change) begin
         next_st.page_cnt = st.page_cnt + 32'h1; // R1
      end
      if (sw_clear) begin
         next_st.en_cnt = 32'h0000_0000; // R6
         next_st.nd_cnt = 32'h0000_0000;
         next_st.page_cnt = 32'h0000_0000;
      end
      if (sw_preset) begin
         next_st.free_cnt = BASE_ADDR + {24'h0, `BMC_OFS_FREE}; // R7
         next_st.en_cnt = BASE_ADDR + {24'h0, `BMC_OFS_EN_CYC};
         next_st.nd_cnt = BASE_ADDR + {24'h0, `BMC_OFS_ND_CYC};
         next_st.page_cnt = BASE_ADDR + {24'h0, `BMC_OFS_PAGE_CNT};
         next_st.count_en = 1'b0; // R7
      end
      next_st.clear_p = sw_clear; // R6
      next_st.preset_p = sw_preset; // R7
      next_st.dbg_pause = pause; // R8
      if (next_st.dbg_out_en) begin
         next_st.mon_bus = {i_graphics_subpacket, i_data_subpacket, i_instr_subpacket,
            i_dma0_subpacket, i_dma1_subpacket, i_exp_subpacket, i_lcd_subpacket}; // R18
      end else begin
         next_st.mon_bus = 33'h0_0000_0000; // R10
      end
   end

   // -----------------------------------------------------------------------
   // State register.
   // -----------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
         st.dbg_out_en <= 1'(`BMC_CTRL_RST); // R10
         st.count_en <= 1'b0; // R5
         st.page_size <= `BMC_PAGE_SIZE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_prdata = st.prdata;
   assign o_pready = st.pready;
   assign o_pslverr = st.pslverr;
   assign o_monitor_output_bus = st.mon_bus;
   assign o_counter_enable = st.count_en;
   assign o_counter_clear = st.clear_p;
   assign o_counter_preset = st.preset_p;
   assign o_debug_pause = st.dbg_pause;

   // -----------------------------------------------------------------------
   // Checks.
   // -----------------------------------------------------------------------
   sequence sw_write_s(logic [7:0] ofs);
      i_psel && i_penable && o_pready && i_pwrite && addr == ofs;
   endsequence

   sequence no_sw_s;
      !sw_clear && !sw_preset;
   endsequence

   sequence read_s(logic [7:0] ofs);
      i_psel && !i_penable && !i_pwrite && addr == ofs ##1 i_psel && i_penable;
   endsequence

   free_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R12
      !sw_preset |=> st.free_cnt == $past(st.free_cnt) + 32'h1)
      else $error("Free cycle counter did not advance.");
   clear_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R6
      sw_write_s(`BMC_OFS_CLEAR) |=>
      st.en_cnt == 0 && st.nd_cnt == 0 && st.page_cnt == 0 && o_counter_clear)
      else $error("Clear write did not zero counters.");
   preset_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R7
      sw_write_s(`BMC_OFS_PRESET) |=> !st.count_en &&
      st.en_cnt == BASE_ADDR + {24'h0, `BMC_OFS_EN_CYC} ##1
      st.en_cnt == $past(st.en_cnt))
      else $error("Preset did not load and hold counters.");
   en_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R13
      (st.count_en and no_sw_s) |=> st.en_cnt == $past(st.en_cnt) + 32'h1)
      else $error("Enabled cycle counter missed a cycle.");
   hold_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R9
      (!st.count_en and no_sw_s) |=> $stable(st.en_cnt) && $stable(st.page_cnt))
      else $error("Counter moved while disabled.");
   nd_pause_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R14
      (st.dbg_gate && i_debug_acknowledge and no_sw_s) |=>
      $stable(st.nd_cnt) && o_debug_pause)
      else $error("Non-debug counter ran during gated acknowledge.");
   page_inc_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R1
      (st.count_en && pif.page_change and no_sw_s) |=>
      st.page_cnt == $past(st.page_cnt) + 32'h1)
      else $error("Page change not counted.");
   dbg_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R10
      (sw_write_s(`BMC_OFS_CTRL) and !i_pwdata[`BMC_CTRL_DBG_OUT]) |=>
      o_monitor_output_bus == 0)
      else $error("Debug output not silenced.");
   page_size_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R2
      sw_write_s(`BMC_OFS_PAGE_SIZE) |=> st.page_size == $past(i_pwdata[1:0]))
      else $error("Page size not stored.");
   id_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R15
      read_s(`BMC_OFS_PERIPH_ID0) |-> o_pready && o_prdata == {24'h0, PART_NUMBER[7:0]})
      else $error("Identity byte read wrong.");
endmodule
`default_nettype wire

// >>> shared/bmc_consts.svh
// Purpose: Offsets, field positions, reset values for the bus monitor control.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Included by the design files and the testbench.
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH
// -----------------------------------------------------------------------
// Register byte offsets.
// -----------------------------------------------------------------------
`define BMC_OFS_CTRL 8'h00
`define BMC_OFS_PAGE_SIZE 8'h04
`define BMC_OFS_CLEAR 8'h08
`define BMC_OFS_PRESET 8'h0c
`define BMC_OFS_FREE 8'h10
`define BMC_OFS_EN_CYC 8'h14
`define BMC_OFS_ND_CYC 8'h18
`define BMC_OFS_PAGE_CNT 8'h1c
`define BMC_OFS_PERIPH_ID0 8'h20
`define BMC_OFS_CELL_ID0 8'h30
`define BMC_ID_BLOCK_MASK 8'hf0
// -----------------------------------------------------------------------
// Control fields and reset values.
// -----------------------------------------------------------------------
`define BMC_CTRL_DBG_OUT 0
`define BMC_CTRL_COUNT_EN 1
`define BMC_CTRL_DBG_GATE 2
`define BMC_CTRL_RST 3'h1
`define BMC_PAGE_SIZE_RST 2'h0
`define BMC_PAGE_SHIFT_BASE 5'h0b
`define BMC_ID_CONFIG 8'h00
`endif

// >>> shared/bmc_pkg.sv
// Purpose: Types shared by the bus monitor control modules.
// Assumes: Nothing beyond the constants header.
// Notes: Each module keeps all its state in one packed struct.
package bmc_pkg;
   typedef struct packed {
      logic dbg_gate;
      logic count_en;
      logic dbg_out_en;
      logic [1:0] page_size;
      logic [31:0] free_cnt;
      logic [31:0] en_cnt;
      logic [31:0] nd_cnt;
      logic [31:0] page_cnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [32:0] mon_bus;
      logic clear_p;
      logic preset_p;
      logic dbg_pause;
   } bmc_top_s;
   typedef struct packed {
      logic have_prev;
      logic [31:0] last_page;
      logic change;
   } bmc_trk_s;
endpackage

// >>> shared/bmc_page_if.sv
// Purpose: Carries graphics transfers to the page tracker and its answer back.
// Assumes: Single clock domain.
// Notes: page_change is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface bmc_page_if;
   logic xfer_valid;
   logic [31:0] xfer_addr;
   logic [1:0] page_size;
   logic page_change;
   modport ctrl (output xfer_valid, output xfer_addr, output page_size, input page_change);
   modport tracker (input xfer_valid, input xfer_addr, input page_size, output page_change);
endinterface
`default_nettype wire

// >>> design/bmc_page_tracker.sv
// Purpose: Flags graphics transfers that land in a page other than the last one.
// Assumes: Each accepted transfer is one single-word access.
// Notes: Pulse appears one cycle after the transfer; the first transfer never flags.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.svh"
module bmc_page_tracker
   import bmc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   bmc_page_if.tracker pif
);
   bmc_trk_s st;
   bmc_trk_s next_st;
   logic [4:0] shift;
   logic [31:0] cur_page;

   // -----------------------------------------------------------------------
   // Page comparison.
   // -----------------------------------------------------------------------
   always_comb begin
      shift = `BMC_PAGE_SHIFT_BASE + {3'h0, pif.page_size}; // R2
      cur_page = pif.xfer_addr >> shift; // R20
      next_st = st;
      next_st.change = 1'b0;
      if (pif.xfer_valid) begin // R4
         next_st.change = st.have_prev && (cur_page != st.last_page); // R1
         next_st.last_page = cur_page; // R20
         next_st.have_prev = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pif.page_change = st.change;

   sequence new_page_s;
      pif.xfer_valid && st.have_prev && (cur_page != st.last_page);
   endsequence

   page_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R1
      new_page_s |=> pif.page_change)
      else $error("Page change not flagged.");
   same_page_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // R20
      pif.xfer_valid && (cur_page == st.last_page) |=> !pif.page_change)
      else $error("Page change flagged within one page.");
endmodule
`default_nettype wire

// >>> tb/bmc_gfx_model.sv
// Purpose: Graphics master and its acceptance, as seen by the monitor.
// Assumes: A run is started just after a rising clock edge.
// Notes: Between runs the address shows the inverse of its last value.
`timescale 1ns/10ps
`default_nettype none
module bmc_gfx_model (
   input wire logic i_sys_clk,
   output logic o_request,
   output logic o_ready,
   output logic [31:0] o_address
);
   // ----------------------------------------------------------------
   // One request per word, each optionally stalled for one cycle.
   // ----------------------------------------------------------------
   initial begin
      o_request = 1'b0;
      o_ready = 1'b0;
      o_address = 32'h0;
   end
   task automatic run(input logic [31:0] addrs[$], input bit slow);
      foreach (addrs[k]) begin
         o_request <= 1'b1;
         o_address <= addrs[k];
         o_ready <= ~slow;
         @(posedge i_sys_clk);
         if (slow) begin
            o_ready <= 1'b1;
            @(posedge i_sys_clk);
         end
      end
      o_request <= 1'b0;
      o_ready <= 1'b0;
      o_address <= ~addrs[addrs.size()-1];
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the bus monitor control block.
// Assumes: APB answers within a bounded wait; one clock domain.
// Notes: Bus replies are matched to queued expectations in issue order.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_consts.svh"
module testbench;
   // ----------------------------------------------------------------
   // Signals and expectations.
   // ----------------------------------------------------------------
   // Identity values below are arbitrary.
   localparam logic [63:0] IDS = {32'h7a3c_91e5, 8'h00, 4'h0, 8'h6b, 12'h1d4};
   typedef struct {logic [31:0] lo; logic [31:0] hi; logic [31:0] m; logic err;} bmc_note_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic ack = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [32:0] sp = 33'h0;
   logic [32:0] mon;
   logic [31:0] prdata, gaddr;
   logic pready, pslverr, cen, cclr, cpre, dpause, greq, grdy;
   logic [31:0] prev_a = 32'h0;
   bit have_prev = 1'b0;
   int failures = 0;
   int n_compared = 0;
   int exp_clr = 0;
   int exp_pages = 0;
   int psz = 0;
   int tb_cyc, n_clr, n_pre;
   bmc_note_s notes[$];
   bmc_note_s cur;
   initial begin
      forever #12.5 clk = ~clk;
   end
   bmc_top #(.REVISION(IDS[23:20]), .DESIGNER(IDS[19:12]), .PART_NUMBER(IDS[11:0]),
      .CELL_ID(IDS[63:32])) dut_u (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_graphics_transfer_request(greq),
      .i_graphics_address_ready(grdy), .i_graphics_address(gaddr),
      .i_debug_acknowledge(ack), .i_graphics_subpacket(sp[32:29]),
      .i_data_subpacket(sp[28:23]), .i_instr_subpacket(sp[22:19]),
      .i_dma0_subpacket(sp[18:14]), .i_dma1_subpacket(sp[13:9]), .i_exp_subpacket(sp[8:4]),
      .i_lcd_subpacket(sp[3:0]), .o_monitor_output_bus(mon), .o_counter_enable(cen),
      .o_counter_clear(cclr), .o_counter_preset(cpre), .o_debug_pause(dpause));
   bmc_gfx_model gfx_u (.i_sys_clk(clk), .o_request(greq), .o_ready(grdy), .o_address(gaddr));
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tb_cyc <= 0;
         n_clr <= 0;
         n_pre <= 0;
      end else begin
         tb_cyc <= tb_cyc + 1;
         n_clr <= n_clr + int'(cclr === 1'b1);
         n_pre <= n_pre + int'(cpre === 1'b1);
      end
   end
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            chk(1'b0, "reply with nothing pending");
         end else begin
            cur = notes.pop_front();
            chk((pslverr === cur.err) && (((prdata & cur.m) === cur.lo) ||
               ((prdata & cur.m) > cur.lo && (prdata & cur.m) <= cur.hi)), "bus reply");
         end
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic chk(input bit ok, input string what);
      n_compared++;
      if (!ok) begin
         failures++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, lo, hi, m,
      input logic err);
      int n;
      @(posedge clk);
      notes.push_back('{lo, hi, m, err});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      apb(1'b0, a, 32'h0, v, v, m, 1'b0);
   endtask
   task automatic gfx(input logic [31:0] q[$], input bit slow, input bit en);
      foreach (q[k]) begin
         if (have_prev && en && ((q[k] >> (11 + psz)) != (prev_a >> (11 + psz)))) exp_pages++;
         have_prev = 1'b1;
         prev_a = q[k];
      end
      gfx_u.run(q, slow);
   endtask
   task automatic summarize();
      if (notes.size() != 0) failures++;
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q[$];
      logic [31:0] p;
      int t1, t2, t3;
      sp <= 33'({$urandom(32'heff95373), $urandom});
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(`BMC_OFS_CTRL, 32'h1, 32'h7);
      rd(`BMC_OFS_PAGE_SIZE, 32'h0, 32'h3);
      for (int k = 0; k < 8; k++) rd(8'(8'h20 + 4 * k), 32'(IDS[8*k +: 8]), '1);
      apb(1'b0, 8'h40, 32'h0, 32'h0, 32'h0, '1, 1'b1);
      wr(8'h20, '1);
      rd(8'h20, 32'(IDS[7:0]), '1);
      apb(1'b0, `BMC_OFS_FREE, 32'h0, tb_cyc, tb_cyc + 8, '1, 1'b0);
      chk(mon === sp, "monitor bus after reset");
      q = {32'h0, 32'h800, 32'h1000, 32'h0};
      gfx(q, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      rd(`BMC_OFS_PAGE_CNT, 32'h0, '1);
      for (int s = 0; s < 4; s++) begin
         psz = s;
         p = 32'h800 << s;
         wr(`BMC_OFS_PAGE_SIZE, 32'(s));
         rd(`BMC_OFS_PAGE_SIZE, 32'(s), 32'h3);
         wr(`BMC_OFS_CLEAR, $urandom);
         exp_clr++;
         exp_pages = 0;
         wr(`BMC_OFS_CTRL, 32'h3);
         q = {32'h0, p - 4, p, p + 4, $urandom, $urandom, 32'h0};
         gfx(q, s[0], 1'b1);
         repeat (3) @(posedge clk);
         rd(`BMC_OFS_PAGE_CNT, 32'(exp_pages), '1);
      end
      wr(`BMC_OFS_CTRL, 32'h1);
      wr(`BMC_OFS_CLEAR, 32'h0);
      exp_clr++;
      ack <= 1'b1;
      wr(`BMC_OFS_CTRL, 32'h7);
      t1 = tb_cyc;
      repeat (5) @(posedge clk);
      chk(cen === 1'b1 && dpause === 1'b1, "enable or pause output");
      wr(`BMC_OFS_CTRL, 32'h5);
      t2 = tb_cyc - t1;
      rd(`BMC_OFS_EN_CYC, 32'(t2), '1);
      rd(`BMC_OFS_ND_CYC, 32'h0, '1);
      wr(`BMC_OFS_CTRL, 32'h3);
      t1 = tb_cyc;
      repeat (3) @(posedge clk);
      wr(`BMC_OFS_CTRL, 32'h1);
      t3 = tb_cyc - t1;
      rd(`BMC_OFS_EN_CYC, 32'(t2 + t3), '1);
      rd(`BMC_OFS_ND_CYC, 32'(t3), '1);
      ack <= 1'b0;
      wr(`BMC_OFS_CLEAR, $urandom);
      exp_clr++;
      rd(`BMC_OFS_EN_CYC, 32'h0, '1);
      rd(`BMC_OFS_ND_CYC, 32'h0, '1);
      rd(`BMC_OFS_PAGE_CNT, 32'h0, '1);
      apb(1'b0, `BMC_OFS_FREE, 32'h0, tb_cyc, tb_cyc + 8, '1, 1'b0);
      wr(`BMC_OFS_CTRL, 32'h3);
      wr(`BMC_OFS_PRESET, $urandom);
      t1 = tb_cyc;
      rd(`BMC_OFS_CTRL, 32'h1, 32'h7);
      rd(`BMC_OFS_EN_CYC, 32'h14, '1);
      rd(`BMC_OFS_ND_CYC, 32'h18, '1);
      rd(`BMC_OFS_PAGE_CNT, 32'h1c, '1);
      apb(1'b0, `BMC_OFS_FREE, 32'h0, 32'h10, 32'h18 + tb_cyc - t1, '1, 1'b0);
      wr(`BMC_OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk(mon === 33'h0, "monitor bus while off");
      sp <= 33'({$urandom, $urandom});
      wr(`BMC_OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(mon === sp, "monitor bus after enable");
      chk(n_clr === exp_clr && n_pre === 1, "clear or preset pulses");
      summarize();
   end
   initial begin
      repeat (6000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
